/* File: verilog/tcp_cfg.svh */
// Register offsets, field positions and reset values for the PWM timer block
`ifndef TCP_CFG_SVH
`define TCP_CFG_SVH
`define TCP_RUN_OFS 12'h000
`define TCP_MODE_OFS 12'h004
`define TCP_FUNC_OFS 12'h008
`define TCP_OUTC_OFS 12'h00c
`define TCP_CNT2_OFS 12'h010
`define TCP_CNT3_OFS 12'h014
`define TCP_CNT4_OFS 12'h018
`define TCP_PER_OFS 12'h01c
`define TCP_PH1_OFS 12'h020
`define TCP_PH2_OFS 12'h024
`define TCP_PH3_OFS 12'h028
`define TCP_BUF1_OFS 12'h02c
`define TCP_BUF2_OFS 12'h030
`define TCP_BUF3_OFS 12'h034
`define TCP_STAT_OFS 12'h038
`define TCP_RUN2_BIT 0
`define TCP_RUN3_BIT 1
`define TCP_RUN4_BIT 2
`define TCP_PHASE_EN_BIT 0
`define TCP_FLAG_DIRECTION_SELECT_BIT 1
`define TCP_CMD_LO_BIT 0
`define TCP_CMD_HI_BIT 1
`define TCP_BUFA3_BIT 2
`define TCP_BUFB3_BIT 3
`define TCP_BUFB4_BIT 4
`define TCP_CAPB3_BIT 5
`define TCP_CH3_OUTPUT_LEVEL_SELECT_BIT 0
`define TCP_CH4_OUTPUT_LEVEL_SELECT_BIT 1
`define TCP_CNT_RST 16'h0000
`define TCP_REG_RST 16'hffff
`define TCP_CNT_ONE 16'h0001
`define TCP_CNT_MAX 16'hffff
`endif

/* File: verilog/tcp_pkg.sv */
// Types shared by the PWM timer block
package tcp_pkg;
  typedef enum logic [1:0] {
    TCP_MODE_NORMAL = 2'b00,
    TCP_MODE_NORMAL2 = 2'b01,
    TCP_MODE_RSYNC = 2'b10,
    TCP_MODE_COMPL = 2'b11
  } tcp_mode_t;
  typedef struct packed {
    logic out1;
    logic out1_neg;
    logic out2;
    logic out2_neg;
    logic out3;
    logic out3_neg;
  } tcp_pwm_t;
  typedef struct packed {
    logic cmp_a3_flag;
    logic ovf4_flag;
    logic ovf2_flag;
    logic cap_b3_flag;
    logic dir_down;
    logic ch2_dir_down;
  } tcp_stat_t;
endpackage

/* File: verilog/tcp_quad.sv */
// Quadrature decoder for the channel 2 phase inputs
`timescale 1ns/100ps
`default_nettype none
module tcp_quad (
  input wire logic mclk_i,     // System clock
  input wire logic sys_rst_i,  // Async reset, active high
  input wire logic phase_a_i,  // Phase input A pin
  input wire logic phase_b_i,  // Phase input B pin
  output logic up_o,           // Count up pulse
  output logic down_o          // Count down pulse
);
  logic [1:0] sync_a;
  logic [1:0] sync_b;
  logic prev_a;
  logic prev_b;
  logic a_rise, a_fall, b_rise, b_fall;

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sync_a <= 2'h0;
      sync_b <= 2'h0;
      prev_a <= 1'b0;
      prev_b <= 1'b0;
    end else begin
      sync_a <= {sync_a[0], phase_a_i};
      sync_b <= {sync_b[0], phase_b_i};
      prev_a <= sync_a[1];
      prev_b <= sync_b[1];
    end
  end

  assign a_rise = sync_a[1] & ~prev_a;
  assign a_fall = ~sync_a[1] & prev_a;
  assign b_rise = sync_b[1] & ~prev_b;
  assign b_fall = ~sync_b[1] & prev_b;

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      up_o <= 1'b0;
      down_o <= 1'b0;
    end else begin
      up_o <= (b_rise & ~prev_a) | (a_rise & prev_b) |
              (b_fall & prev_a) | (a_fall & ~prev_b);
      down_o <= (b_rise & prev_a) | (a_fall & prev_b) |
                (b_fall & ~prev_a) | (a_rise & ~prev_b);
    end
  end
endmodule // tcp_quad
`default_nettype wire

/* File: verilog/tcp_timer.sv */
// Complementary PWM, buffer and phase counting timer with APB slave
`timescale 1ns/100ps
`default_nettype none
`include "tcp_cfg.svh"
module tcp_timer
  import tcp_pkg::*;
#(
  parameter int CW = 16 // Counter width
) (
  input wire logic mclk_i,          // System clock, 10 MHz
  input wire logic sys_rst_i,       // Async reset, active high
  input wire logic psel,            // APB select
  input wire logic penable,         // APB enable
  input wire logic pwrite,          // APB write
  input wire logic [11:0] paddr,    // APB byte address
  input wire logic [31:0] pwdata,   // APB write data
  output logic [31:0] prdata,       // APB read data
  output logic pready,              // APB ready
  output logic pslverr,             // APB error
  input wire logic phase_a_i,       // Phase input A pin
  input wire logic phase_b_i,       // Phase input B pin
  input wire logic capture_b3_i,    // Capture strobe for phase 1 reg
  output tcp_pwm_t pwm_o,           // Six PWM pins
  output logic pwm_en_o             // PWM pins in use
);
  logic [2:0] run_control;
  logic [1:0] timer_mode_register;
  logic [5:0] function_control;
  logic [1:0] output_control;
  logic [CW-1:0] ch2_counter, ch3_counter, ch4_counter;
  logic [CW-1:0] period_compare, phase1_compare;
  logic [CW-1:0] phase2_compare, phase3_compare;
  logic [CW-1:0] buf1, buf2, buf3;
  tcp_stat_t stat;
  logic [2:0] ph;
  logic [2:0] cap_sync;
  logic q_up, q_dn;
  tcp_mode_t mode;
  logic wr, rd, down;
  logic per_match, unf4, ovf4_ev, cmpa3_ev, ph1_m, ph2_m, ph3_m, cap_ev;
  logic load_buf;
  logic [31:0] next_rdata;
  logic adr_ok;

  function automatic logic hit(input logic [CW-1:0] cnt,
                               input logic [CW-1:0] cmp,
                               input logic [CW-1:0] per);
    hit = (cnt == cmp) && (cmp <= per);
  endfunction

  function automatic logic [CW-1:0] step(input logic [CW-1:0] cnt,
                                         input logic dn);
    step = dn ? cnt - CW'(`TCP_CNT_ONE) : cnt + CW'(`TCP_CNT_ONE);
  endfunction

  tcp_quad u_quad (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .phase_a_i(phase_a_i),
    .phase_b_i(phase_b_i),
    .up_o(q_up),
    .down_o(q_dn)
  );

  assign mode = tcp_mode_t'({function_control[`TCP_CMD_HI_BIT],
                             function_control[`TCP_CMD_LO_BIT]});
  assign wr = psel & penable & pwrite;
  assign rd = psel & ~pwrite;
  assign cap_ev = cap_sync[1] & ~cap_sync[2];
  assign per_match = run_control[`TCP_RUN3_BIT] &&
                     (ch3_counter == period_compare);
  assign unf4 = (mode == TCP_MODE_COMPL) && run_control[`TCP_RUN4_BIT] &&
                down && (ch4_counter == CW'(`TCP_CNT_RST));
  assign ovf4_ev = (mode == TCP_MODE_COMPL) ? unf4 :
                   (run_control[`TCP_RUN4_BIT] &&
                    ch4_counter == CW'(`TCP_CNT_MAX));
  assign cmpa3_ev = per_match && !(mode == TCP_MODE_COMPL && down);
  assign ph1_m = run_control[`TCP_RUN3_BIT] &&
                 hit(ch3_counter, phase1_compare, period_compare);
  assign ph2_m = hit(ch4_counter, phase2_compare, period_compare);
  assign ph3_m = hit(ch4_counter, phase3_compare, period_compare);

  always_comb begin
    case (mode)
      TCP_MODE_COMPL: load_buf = (per_match && !down) || unf4;
      TCP_MODE_RSYNC: load_buf = per_match;
      default: load_buf = 1'b0;
    endcase
  end

  // Capture strobe from the pin
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cap_sync <= 3'h0;
    end else begin
      cap_sync <= {cap_sync[1:0], capture_b3_i};
    end
  end

  // Control registers
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      run_control <= 3'h0;
      timer_mode_register <= 2'h0;
      function_control <= 6'h00;
      output_control <= 2'h0;
    end else if (wr) begin
      if (paddr == `TCP_RUN_OFS) begin
        run_control <= pwdata[2:0];
      end else if (paddr == `TCP_MODE_OFS) begin
        timer_mode_register <= pwdata[1:0];
      end else if (paddr == `TCP_FUNC_OFS) begin
        function_control <= pwdata[5:0];
      end else if (paddr == `TCP_OUTC_OFS) begin
        output_control <= pwdata[1:0];
      end
    end
  end

  // Channel 2: phase counting or free-running up counter
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ch2_counter <= CW'(`TCP_CNT_RST);
    end else if (wr && paddr == `TCP_CNT2_OFS) begin
      ch2_counter <= pwdata[CW-1:0];
    end else if (run_control[`TCP_RUN2_BIT]) begin
      if (timer_mode_register[`TCP_PHASE_EN_BIT]) begin
        if (q_up) begin
          ch2_counter <= step(ch2_counter, 1'b0);
        end else if (q_dn) begin
          ch2_counter <= step(ch2_counter, 1'b1);
        end
      end else begin
        ch2_counter <= step(ch2_counter, 1'b0);
      end
    end
  end

  // Channels 3 and 4 counters and count direction
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ch3_counter <= CW'(`TCP_CNT_RST);
      ch4_counter <= CW'(`TCP_CNT_RST);
      down <= 1'b0;
    end else begin
      if (mode == TCP_MODE_COMPL) begin
        if (per_match && !down) begin
          down <= 1'b1;
        end else if (unf4) begin
          down <= 1'b0;
        end
      end else begin
        down <= 1'b0;
      end
      if (wr && paddr == `TCP_CNT3_OFS) begin
        ch3_counter <= pwdata[CW-1:0];
      end else if (run_control[`TCP_RUN3_BIT]) begin
        if (mode == TCP_MODE_RSYNC && per_match) begin
          ch3_counter <= CW'(`TCP_CNT_RST);
        end else if (mode == TCP_MODE_COMPL) begin
          ch3_counter <= step(ch3_counter,
                              (down || per_match) && !unf4);
        end else begin
          ch3_counter <= step(ch3_counter, 1'b0);
        end
      end
      if (wr && paddr == `TCP_CNT4_OFS) begin
        ch4_counter <= pwdata[CW-1:0];
      end else if (run_control[`TCP_RUN4_BIT]) begin
        if (mode == TCP_MODE_COMPL) begin
          ch4_counter <= step(ch4_counter,
                              (down || per_match) && !unf4);
        end else begin
          ch4_counter <= step(ch4_counter, 1'b0);
        end
      end
    end
  end

  // General compare registers with buffer transfers
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      period_compare <= CW'(`TCP_REG_RST);
      phase1_compare <= CW'(`TCP_REG_RST);
      phase2_compare <= CW'(`TCP_REG_RST);
      phase3_compare <= CW'(`TCP_REG_RST);
    end else begin
      if (wr && paddr == `TCP_PER_OFS) begin
        period_compare <= pwdata[CW-1:0];
      end else if (function_control[`TCP_BUFA3_BIT] &&
                   mode != TCP_MODE_COMPL && mode != TCP_MODE_RSYNC &&
                   per_match) begin
        period_compare <= buf1;
      end
      if (function_control[`TCP_CAPB3_BIT] && cap_ev) begin
        phase1_compare <= ch3_counter;
      end else if (wr && paddr == `TCP_PH1_OFS) begin
        phase1_compare <= pwdata[CW-1:0];
      end else if (function_control[`TCP_BUFB3_BIT] &&
                   (load_buf || (mode[1] == 1'b0 && ph1_m))) begin
        phase1_compare <= buf2;
      end
      if (wr && paddr == `TCP_PH2_OFS) begin
        phase2_compare <= pwdata[CW-1:0];
      end
      if (wr && paddr == `TCP_PH3_OFS) begin
        phase3_compare <= pwdata[CW-1:0];
      end else if (function_control[`TCP_BUFB4_BIT] &&
                   (load_buf || (mode[1] == 1'b0 && ph3_m))) begin
        phase3_compare <= buf3;
      end
    end
  end

  // Buffer registers
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      buf1 <= CW'(`TCP_REG_RST);
      buf2 <= CW'(`TCP_REG_RST);
      buf3 <= CW'(`TCP_REG_RST);
    end else begin
      if (wr && paddr == `TCP_BUF1_OFS) begin
        buf1 <= pwdata[CW-1:0];
      end
      if (function_control[`TCP_BUFB3_BIT] &&
          function_control[`TCP_CAPB3_BIT] && cap_ev) begin
        buf2 <= phase1_compare;
      end else if (wr && paddr == `TCP_BUF2_OFS) begin
        buf2 <= pwdata[CW-1:0];
      end
      if (wr && paddr == `TCP_BUF3_OFS) begin
        buf3 <= pwdata[CW-1:0];
      end
    end
  end

  // Status flags sticky, write one to clear, direction bits live; a new event wins
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      stat <= '0;
    end else begin
      stat.dir_down <= down;
      stat.ch2_dir_down <= q_dn & ~q_up;
      if (cmpa3_ev) begin
        stat.cmp_a3_flag <= 1'b1;
      end else if (wr && paddr == `TCP_STAT_OFS && pwdata[5]) begin
        stat.cmp_a3_flag <= 1'b0;
      end
      if (ovf4_ev) begin
        stat.ovf4_flag <= 1'b1;
      end else if (wr && paddr == `TCP_STAT_OFS && pwdata[4]) begin
        stat.ovf4_flag <= 1'b0;
      end
      if (run_control[`TCP_RUN2_BIT] &&
          ((timer_mode_register[`TCP_FLAG_DIRECTION_SELECT_BIT] && q_dn &&
            ch2_counter == CW'(`TCP_CNT_RST)) ||
           (ch2_counter == CW'(`TCP_CNT_MAX) &&
            (q_up || !timer_mode_register[`TCP_PHASE_EN_BIT])))) begin
        stat.ovf2_flag <= 1'b1;
      end else if (wr && paddr == `TCP_STAT_OFS && pwdata[3]) begin
        stat.ovf2_flag <= 1'b0;
      end
      if (cap_ev && function_control[`TCP_CAPB3_BIT]) begin
        stat.cap_b3_flag <= 1'b1;
      end else if (wr && paddr == `TCP_STAT_OFS && pwdata[2]) begin
        stat.cap_b3_flag <= 1'b0;
      end
    end
  end

  // Phase state: ch3, ch4, ch4 match order in complementary mode
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ph <= 3'h0;
    end else if (mode == TCP_MODE_COMPL) begin
      if (ph1_m) begin
        ph[0] <= ~down;
      end
      if (ph2_m) begin
        ph[1] <= ~down;
      end
      if (ph3_m) begin
        ph[2] <= ~down;
      end
    end else if (mode == TCP_MODE_RSYNC) begin
      if (per_match) begin
        ph <= 3'h7;
      end else begin
        if (ph1_m) begin
          ph[0] <= 1'b0;
        end
        if (ch3_counter == phase2_compare) begin
          ph[1] <= 1'b0;
        end
        if (ch3_counter == phase3_compare) begin
          ph[2] <= 1'b0;
        end
      end
    end else begin
      ph <= 3'h0;
    end
  end

  // Pin drive with level inversion
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pwm_o <= '0;
      pwm_en_o <= 1'b0;
    end else begin
      pwm_en_o <= mode[1];
      if (mode[1]) begin
        pwm_o.out1 <= ph[0] ^ output_control[`TCP_CH3_OUTPUT_LEVEL_SELECT_BIT];
        pwm_o.out1_neg <= ~ph[0] ^ output_control[`TCP_CH3_OUTPUT_LEVEL_SELECT_BIT];
        pwm_o.out2 <= ph[1] ^ output_control[`TCP_CH4_OUTPUT_LEVEL_SELECT_BIT];
        pwm_o.out2_neg <= ~ph[1] ^ output_control[`TCP_CH4_OUTPUT_LEVEL_SELECT_BIT];
        pwm_o.out3 <= ph[2] ^ output_control[`TCP_CH4_OUTPUT_LEVEL_SELECT_BIT];
        pwm_o.out3_neg <= ~ph[2] ^ output_control[`TCP_CH4_OUTPUT_LEVEL_SELECT_BIT];
      end else begin
        pwm_o <= '0;
      end
    end
  end

  // APB read mux
  always_comb begin
    next_rdata = 32'h0000_0000;
    adr_ok = 1'b1;
    if (paddr == `TCP_RUN_OFS) begin
      next_rdata[2:0] = run_control;
    end else if (paddr == `TCP_MODE_OFS) begin
      next_rdata[1:0] = timer_mode_register;
    end else if (paddr == `TCP_FUNC_OFS) begin
      next_rdata[5:0] = function_control;
    end else if (paddr == `TCP_OUTC_OFS) begin
      next_rdata[1:0] = output_control;
    end else if (paddr == `TCP_CNT2_OFS) begin
      next_rdata[CW-1:0] = ch2_counter;
    end else if (paddr == `TCP_CNT3_OFS) begin
      next_rdata[CW-1:0] = ch3_counter;
    end else if (paddr == `TCP_CNT4_OFS) begin
      next_rdata[CW-1:0] = ch4_counter;
    end else if (paddr == `TCP_PER_OFS) begin
      next_rdata[CW-1:0] = period_compare;
    end else if (paddr == `TCP_PH1_OFS) begin
      next_rdata[CW-1:0] = phase1_compare;
    end else if (paddr == `TCP_PH2_OFS) begin
      next_rdata[CW-1:0] = phase2_compare;
    end else if (paddr == `TCP_PH3_OFS) begin
      next_rdata[CW-1:0] = phase3_compare;
    end else if (paddr == `TCP_BUF1_OFS) begin
      next_rdata[CW-1:0] = buf1;
    end else if (paddr == `TCP_BUF2_OFS) begin
      next_rdata[CW-1:0] = buf2;
    end else if (paddr == `TCP_BUF3_OFS) begin
      next_rdata[CW-1:0] = buf3;
    end else if (paddr == `TCP_STAT_OFS) begin
      next_rdata[5:0] = stat;
    end else begin
      adr_ok = 1'b0;
    end
  end

  // Zero-wait APB answer, registered in the setup cycle
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~adr_ok;
      if (rd && !penable) begin
        prdata <= next_rdata;
      end
    end
  end
endmodule // tcp_timer
`default_nettype wire

/* File: verification/tcp_timer_properties.sv */
// Port-level checks for the PWM timer
`timescale 1ns/100ps
`default_nettype none
`include "tcp_cfg.svh"
module tcp_timer_chk
  import tcp_pkg::*;
#(
  parameter int CW = 16 // Counter width
) (
  input wire logic mclk_i, // System clock
  input wire logic sys_rst_i, // Async reset
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB write
  input wire logic [11:0] paddr, // APB address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [31:0] prdata, // APB read data
  input wire logic pready, // APB ready
  input wire logic pslverr, // APB error
  input wire logic phase_a_i, // Phase A pin
  input wire logic phase_b_i, // Phase B pin
  input wire logic capture_b3_i, // Capture pin
  input wire tcp_pwm_t pwm_o, // PWM pins
  input wire logic pwm_en_o // PWM pins in use
);
  logic wr_acc;
  logic [1:0] mode_q;
  logic [1:0] ols_q;
  logic [1:0] settle;
  assign wr_acc = psel && penable && pwrite && pready;
  // Shadow of mode and level select
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mode_q <= 2'h0;
      ols_q <= 2'h0;
    end else if (wr_acc && paddr == `TCP_FUNC_OFS) begin
      mode_q <= pwdata[1:0];
    end else if (wr_acc && paddr == `TCP_OUTC_OFS) begin
      ols_q <= pwdata[1:0];
    end
  end
  // Cycles since a mode or level change
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) settle <= 2'h0;
    else if (wr_acc && (paddr == `TCP_FUNC_OFS ||
        paddr == `TCP_OUTC_OFS)) settle <= 2'h0;
    else if (settle != 2'h3) settle <= settle + 2'h1;
  end
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (sys_rst_i);
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence func_wr_s;
    wr_acc && paddr == `TCP_FUNC_OFS;
  endsequence
  property pins_follow_p;
    func_wr_s |-> ##[1:3] pwm_en_o == mode_q[1];
  endproperty
  property no_overlap_p;
    settle == 2'h3 && mode_q == 2'h3 && ols_q == 2'h0 |->
      pwm_o.out1 != pwm_o.out1_neg && pwm_o.out2 != pwm_o.out2_neg
      && pwm_o.out3 != pwm_o.out3_neg;
  endproperty
  chk_ready_setup: assert property (setup_s |=> pready)
    else $error("no ready after setup");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  chk_ready_idle: assert property (!psel |=> !pready)
    else $error("ready without a transfer");
  chk_err_unmapped: assert property (
    (setup_s and paddr > `TCP_STAT_OFS) |=> pready && pslverr)
    else $error("unmapped address not refused");
  chk_err_mapped: assert property (setup_s && paddr <= `TCP_STAT_OFS
    && paddr[1:0] == 2'h0 |=> !pslverr)
    else $error("mapped address refused");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  chk_err_rdata: assert property (pready && pslverr && !pwrite |->
    prdata == 32'h0) else $error("refused read not zero");
  chk_pins_mode: assert property (pins_follow_p)
    else $error("pin use does not follow mode");
  chk_phase_gap: assert property (no_overlap_p)
    else $error("pair outputs overlap");
endmodule // tcp_timer_chk
`default_nettype wire

/* File: verification/tcp_enc_model.sv */
// Quadrature encoder model driving the two phase pins
`timescale 1ns/100ps
`default_nettype none
module tcp_enc_model (
  output logic phase_a_o, // Phase A to the timer
  output logic phase_b_o, // Phase B to the timer
  input wire logic mclk_i // System clock
);
  logic [1:0] pos = 2'h0;
  initial begin
    phase_a_o = 1'h0;
    phase_b_o = 1'h0;
  end
  // One pin edge per step, Gray order 00 01 11 10 going up
  task automatic move(input int n, input logic up, input int gap);
    for (int i = 0; i < n; i++) begin
      @(posedge mclk_i);
      pos = up ? pos + 2'h1 : pos - 2'h1;
      phase_a_o <= pos[1];
      phase_b_o <= pos[1] ^ pos[0];
      repeat (gap < 3 ? 3 : gap) @(posedge mclk_i);
    end
  endtask
endmodule // tcp_enc_model
`default_nettype wire

/* File: verification/testbench.sv */
// Self-checking bench for the PWM timer
`timescale 1ns/100ps
`default_nettype none
`include "tcp_cfg.svh"
module testbench
  import tcp_pkg::*;
;
  localparam int P = 40;
  localparam int T = 4;
  logic mclk_i = 1'h0;
  logic sys_rst_i = 1'h1;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic capture_b3_i = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic pwm_en_o;
  logic pha;
  logic phb;
  tcp_pwm_t pwm_o;
  int n_errors = 0;
  int checks_done = 0;
  int cycles = 0;
  always #50 mclk_i = ~mclk_i;
  tcp_timer #(.CW(16)) DUT (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .phase_a_i(pha), .phase_b_i(phb), .capture_b3_i(capture_b3_i),
    .pwm_o(pwm_o), .pwm_en_o(pwm_en_o));
  tcp_enc_model enc (.mclk_i(mclk_i), .phase_a_o(pha), .phase_b_o(phb));
  task automatic wrap_up();
    if (n_errors == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  always @(posedge mclk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors = n_errors + 1;
      wrap_up();
    end
  end
  task automatic apb(input logic wr, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] q, output logic e);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk_i);
    penable <= 1'h1;
    @(posedge mclk_i);
    while (pready !== 1'h1) @(posedge mclk_i);
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge mclk_i);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'h1, a, d, q, e);
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] q);
    logic e;
    apb(1'h0, a, 32'h0, q, e);
  endtask
  task automatic chk(input string what, input logic [31:0] exp,
      input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp,
      input string what);
    logic [31:0] q;
    rd(a, q);
    chk(what, exp, q);
  endtask
  function automatic logic [31:0] quad_exp(int up, int dn);
    return {16'h0, 16'(up - dn)};
  endfunction
  initial begin
    logic [31:0] q;
    logic e;
    int n, m, tg1, tg3;
    logic [15:0] v, c, prev;
    logic [1:0] dn;
    tcp_pwm_t p0, p1;
    int md [3] = '{0, 2, 3};
    q = $urandom(51);
    repeat (8) @(posedge mclk_i);
    sys_rst_i <= 1'h0;
    @(posedge mclk_i);
    rdchk(`TCP_PER_OFS, 32'h0000ffff, "period reset");
    rdchk(`TCP_BUF2_OFS, 32'h0000ffff, "buffer reset");
    rdchk(`TCP_CNT3_OFS, 32'h0, "counter reset");
    rdchk(`TCP_FUNC_OFS, 32'h0, "function reset");
    apb(1'h0, 12'h03c, 32'h0, q, e);
    chk("unmapped err", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, q);
    v = 16'($urandom);
    wr(`TCP_BUF3_OFS, {16'hffff, v});
    rdchk(`TCP_BUF3_OFS, {16'h0, v}, "buffer word");
    wr(`TCP_MODE_OFS, 32'h1);
    wr(`TCP_MODE_OFS, 32'h3);
    wr(`TCP_RUN_OFS, 32'h1);
    n = $urandom_range(20, 6);
    m = n + $urandom_range(6, 1);
    enc.move(n, 1'h1, $urandom_range(6, 3));
    repeat (4) @(posedge mclk_i);
    rdchk(`TCP_CNT2_OFS, quad_exp(n, 0), "quad up");
    enc.move(m, 1'h0, 3);
    repeat (4) @(posedge mclk_i);
    rdchk(`TCP_CNT2_OFS, quad_exp(n, m), "quad down");
    rd(`TCP_STAT_OFS, q);
    chk("quad wrap flag", 32'h1, {31'h0, q[3]});
    wr(`TCP_RUN_OFS, 32'h0);
    wr(`TCP_FUNC_OFS, 32'h28);
    prev = 16'hffff;
    repeat (2) begin
      c = 16'($urandom);
      wr(`TCP_CNT3_OFS, {16'h0, c});
      capture_b3_i <= 1'h1;
      repeat (4) @(posedge mclk_i);
      capture_b3_i <= 1'h0;
      repeat (6) @(posedge mclk_i);
      rdchk(`TCP_PH1_OFS, {16'h0, c}, "captured count");
      rdchk(`TCP_BUF2_OFS, {16'h0, prev}, "captured old");
      prev = c;
    end
    rd(`TCP_STAT_OFS, q);
    chk("capture flag", 32'h1, {31'h0, q[2]});
    foreach (md[i]) begin
      wr(`TCP_RUN_OFS, 32'h0);
      wr(`TCP_FUNC_OFS, 32'(md[i]) | 32'h8);
      wr(`TCP_CNT4_OFS, 32'h0);
      wr(`TCP_CNT3_OFS, T);
      wr(`TCP_PER_OFS, P);
      wr(`TCP_PH1_OFS, 32'h0a);
      wr(`TCP_PH2_OFS, 32'h14);
      wr(`TCP_PH3_OFS, P + 5);
      v = 16'($urandom_range(35, 12));
      wr(`TCP_BUF2_OFS, {16'h0, v});
      wr(`TCP_STAT_OFS, 32'h3c);
      chk("pins used", {31'h0, md[i] >= 2}, {31'h0, pwm_en_o});
      wr(`TCP_RUN_OFS, 32'h6);
      dn = 2'h0;
      tg1 = 0;
      tg3 = 0;
      p1 = pwm_o;
      repeat (40) begin
        rd(`TCP_STAT_OFS, q);
        if (q[1] === 1'h1) dn[1] = 1'h1;
        if (q[1] === 1'h0) dn[0] = 1'h1;
        rd(`TCP_CNT3_OFS, q);
        if (md[i] == 3 && q > P + 1) chk("count limit", P + 1, q);
        tg1 += int'(pwm_o.out1 !== p1.out1);
        tg3 += int'(pwm_o.out3 !== p1.out3 || pwm_o.out3_neg !== p1.out3_neg);
        p1 = pwm_o;
      end
      wr(`TCP_RUN_OFS, 32'h0);
      rdchk(`TCP_PH1_OFS, {16'h0, v}, "buffer load");
      if (md[i] == 3) begin
        chk("both directions", 32'h3, {30'h0, dn});
        chk("phase edges", 32'h1, {31'h0, tg1 > 1});
        chk("steady phase", 32'h0, tg3);
        rd(`TCP_STAT_OFS, q);
        chk("turn flags", 32'h3, {30'h0, q[5:4]});
      end
      if (md[i] != 0) begin
        p0 = pwm_o;
        wr(`TCP_OUTC_OFS, 32'h3);
        repeat (3) @(posedge mclk_i);
        chk("inverted", {26'h0, ~p0}, {26'h0, pwm_o});
        wr(`TCP_OUTC_OFS, 32'h0);
        repeat (3) @(posedge mclk_i);
        chk("restored", {26'h0, p0}, {26'h0, pwm_o});
      end
    end
    wrap_up();
  end
endmodule // testbench
bind tcp_timer tcp_timer_chk #(.CW(CW)) u_chk (
  .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .phase_a_i(phase_a_i), .phase_b_i(phase_b_i),
  .capture_b3_i(capture_b3_i), .pwm_o(pwm_o), .pwm_en_o(pwm_en_o));
`default_nettype wire
